// File: tfcc_pkg.sv
`default_nettype none
// ==========================================================
// shared constants for the flow-change capture block
// ==========================================================
package tfcc_pkg;

  // ========================================================
  // entry layout
  // ========================================================
  localparam int ADDR_W        = 18;  // full address bus width
  localparam int INFO_W        = 2;   // info bits per entry
  localparam int INFO_DEST_BIT = 0;   // 1 = destination, 0 = source
  localparam int INFO_VEC_BIT  = 1;   // 1 = interrupt vector entry
  localparam int DEPTH_DEF     = 64;  // default trace buffer depth

  // ========================================================
  // values after reset
  // ========================================================
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [INFO_W-1:0] INFO_RST = 2'h0;

  // info codes for the three entry kinds
  localparam logic [INFO_W-1:0] INFO_SRC = 2'h0;
  localparam logic [INFO_W-1:0] INFO_DST = 2'h1;
  localparam logic [INFO_W-1:0] INFO_VEC = 2'h3;

  // ========================================================
  // instruction classes reported by the core on completion
  // ========================================================
  typedef enum logic [2:0] {
    TFCC_CLS_OTHER,       // no flow change at all
    TFCC_CLS_COND_BRANCH, // conditional branch / loop primitive
    TFCC_CLS_IDX_JUMP,    // indexed jump, subroutine, paged entry
    TFCC_CLS_DIRECT_JUMP, // non-indexed jump, subroutine, paged entry
    TFCC_CLS_RETURN,      // interrupt, subroutine or paged return
    TFCC_CLS_UNCOND_HOP   // hops, short subroutine, background entry
  } tfcc_class_t;

endpackage : tfcc_pkg
`default_nettype wire

// File: tfcc_classify.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// classifier: does a completed instruction make an entry
// ==========================================================
module tfcc_classify
  import tfcc_pkg::*;
(
  input  wire tfcc_class_t i_class,     // class of completed insn
  input  wire logic        i_taken,     // conditional branch taken
  output logic             o_rec_src,   // record source address
  output logic             o_rec_dst    // record destination
);

  // ========================================================
  // decode
  // ========================================================
  // only taken conditional branches keep their source
  assign o_rec_src = (i_class == TFCC_CLS_COND_BRANCH) & i_taken;
  // indexed transfers and returns keep their destination;
  // direct jumps and hops fall to neither output
  assign o_rec_dst = (i_class == TFCC_CLS_IDX_JUMP) |
                     (i_class == TFCC_CLS_RETURN);

endmodule : tfcc_classify
`default_nettype wire

// File: tfcc_capture.sv
// How it works
// - record only flow-change addresses, nothing else
// - taken conditional branch stores its source
// - indexed jump/subroutine/paged entry store destination
// - returns store the destination returned to
// - interrupts store vector, background vectors excluded
// - hops, direct jumps, background entry store nothing
// - entry: 18-bit address plus two info bits, destination and vector
// - destination entry written at instruction completion
// - destination before vector when both coincide
`timescale 1ns/1ps
`default_nettype none
module tfcc_capture
  import tfcc_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF            // trace buffer entries
) (
  input  wire logic              i_clk,        // bus clock, 20 MHz
  input  wire logic              i_rst,        // async, active high
  input  wire logic              i_trace_en,   // normal tracing armed
  input  wire logic              i_insn_done,  // insn completes (pulse)
  input  wire tfcc_class_t       i_insn_class, // class of that insn
  input  wire logic              i_taken,      // branch was taken
  input  wire logic [ADDR_W-1:0] i_insn_addr,  // address of the insn
  input  wire logic [ADDR_W-1:0] i_dest_addr,  // address reached
  input  wire logic              i_irq_taken,  // vector fetch (pulse)
  input  wire logic              i_vec_background_entry_instruction,   // vector is debug state
  input  wire logic [ADDR_W-1:0] i_vec_addr,   // vector address
  output logic                   o_wr_en,      // buffer write strobe
  output logic [$clog2(DEPTH)-1:0] o_wr_idx,   // buffer slot
  output logic [ADDR_W-1:0]      o_wr_addr,    // stored address
  output logic [INFO_W-1:0]      o_wr_info     // stored info bits
);

  localparam int IDX_W = $clog2(DEPTH);

  // ========================================================
  // elaboration check
  // ========================================================
  // the slot index wraps by plain overflow, so only powers of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("tfcc_capture: DEPTH must be a power of two, >= 2");
  end

  // ========================================================
  // classification
  // ========================================================
  logic rec_src;                  // completed insn keeps source
  logic rec_dst;                  // completed insn keeps destination

  tfcc_classify u_classify (
    .i_class   (i_insn_class),
    .i_taken   (i_taken),
    .o_rec_src (rec_src),
    .o_rec_dst (rec_dst)
  );

  // ========================================================
  // event qualification
  // ========================================================
  wire src_ev = i_trace_en & i_insn_done & rec_src;
  // destination entry only once the insn has completed
  wire dst_ev = i_trace_en & i_insn_done & rec_dst;
  // debug-state vectors never reach the buffer
  wire vec_ev = i_trace_en & i_irq_taken & ~i_vec_background_entry_instruction;
  wire cof_ev = src_ev | dst_ev;  // flow change by instruction

  // ========================================================
  // pending slot
  // ========================================================
  // one event per cycle can be written; a second one waits here
  logic              pend_q;      // an entry is waiting
  logic [ADDR_W-1:0] pend_addr_q; // its address
  logic [INFO_W-1:0] pend_info_q; // its info bits

  // ========================================================
  // selection of the entry written this cycle
  // ========================================================
  // fresh entry: instruction first, vector second
  wire [ADDR_W-1:0] new_addr = cof_ev ? (dst_ev ? i_dest_addr
                                                : i_insn_addr)
                                      : i_vec_addr;
  wire [INFO_W-1:0] new_info = cof_ev ? (dst_ev ? INFO_DST
                                                : INFO_SRC)
                                      : INFO_VEC;
  // anything other than these three sources writes nothing
  wire wr_now = pend_q | cof_ev | vec_ev;
  // a waiting entry is older, so it goes out first
  wire [ADDR_W-1:0] wr_addr_d = pend_q ? pend_addr_q : new_addr;
  wire [INFO_W-1:0] wr_info_d = pend_q ? pend_info_q : new_info;
  // destination and vector together: vector waits one cycle
  wire pend_d = pend_q ? (cof_ev | vec_ev)
                       : (cof_ev & vec_ev);
  // limitation: cof and vec together while busy drops the vector
  wire [ADDR_W-1:0] pend_addr_d = pend_q ? new_addr : i_vec_addr;
  wire [INFO_W-1:0] pend_info_d = pend_q ? new_info : INFO_VEC;

  // ========================================================
  // registers
  // ========================================================
  logic [IDX_W-1:0] next_idx_q;   // slot for the next entry

  // pending slot
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_q      <= 1'b0;
      pend_addr_q <= ADDR_RST;
      pend_info_q <= INFO_RST;
    end else begin
      pend_q      <= pend_d;
      pend_addr_q <= pend_addr_d;
      pend_info_q <= pend_info_d;
    end
  end

  // write port, straight from flip-flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_en   <= 1'b0;
      o_wr_addr <= ADDR_RST;
      o_wr_info <= INFO_RST;
    end else begin
      o_wr_en   <= wr_now;
      o_wr_addr <= wr_addr_d;
      o_wr_info <= wr_info_d;
    end
  end

  // slot index, one step per entry
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      next_idx_q <= '0;
      o_wr_idx   <= '0;
    end else if (wr_now) begin
      o_wr_idx   <= next_idx_q;
      next_idx_q <= IDX_W'(next_idx_q + 1'b1);
    end
  end

  // ========================================================
  // helper state for the assertions
  // ========================================================
  logic             seen_q;       // at least one entry written
  logic [IDX_W-1:0] last_idx_q;   // slot of the previous entry

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seen_q     <= 1'b0;
      last_idx_q <= '0;
    end else if (o_wr_en) begin
      seen_q     <= 1'b1;
      last_idx_q <= o_wr_idx;
    end
  end

  wire is_ret  = (i_insn_class == TFCC_CLS_RETURN);
  wire is_idx  = (i_insn_class == TFCC_CLS_IDX_JUMP);
  wire is_br   = (i_insn_class == TFCC_CLS_COND_BRANCH) & i_taken;
  // flow change judged from the raw inputs, so a broken classifier
  // shows up instead of agreeing with itself
  wire raw_ev  = i_trace_en & ((i_irq_taken & ~i_vec_background_entry_instruction) |
                 (i_insn_done & (is_br | is_idx | is_ret)));
  wire is_none = (i_insn_class == TFCC_CLS_DIRECT_JUMP) |
                 (i_insn_class == TFCC_CLS_UNCOND_HOP);

  // ========================================================
  // assertions
  // ========================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_only_flow_change: assert property (
    o_wr_en |-> $past(pend_q || raw_ev))
    else $error("entry written without a flow change");

  a_branch_source: assert property (
    (i_trace_en && i_insn_done && is_br && !pend_q) |=>
      o_wr_en && o_wr_info == INFO_SRC &&
      o_wr_addr == $past(i_insn_addr))
    else $error("taken branch source not stored");

  a_indexed_dest: assert property (
    (i_trace_en && i_insn_done && is_idx && !pend_q) |=>
      o_wr_en && o_wr_info == INFO_DST &&
      o_wr_addr == $past(i_dest_addr))
    else $error("indexed transfer destination not stored");

  a_return_dest: assert property (
    (i_trace_en && i_insn_done && is_ret && !pend_q) |=>
      o_wr_en && o_wr_info == INFO_DST &&
      o_wr_addr == $past(i_dest_addr))
    else $error("return destination not stored");

  a_vector_entry: assert property (
    (i_trace_en && i_irq_taken && !i_insn_done && !pend_q) |=>
      (o_wr_en == !$past(i_vec_background_entry_instruction)) &&
      (!o_wr_en || o_wr_addr == $past(i_vec_addr)))
    else $error("vector entry wrong or debug vector stored");

  a_no_plain_jump: assert property (
    (i_insn_done && is_none && !i_irq_taken && !pend_q) |=> !o_wr_en)
    else $error("non-flow-change instruction stored");

  a_info_legal: assert property (
    o_wr_en |-> (o_wr_info == INFO_SRC || o_wr_info == INFO_DST ||
                 o_wr_info == INFO_VEC))
    else $error("illegal info bits in entry");

  a_dest_at_done: assert property (
    (o_wr_en && o_wr_info == INFO_DST) |->
      $past(pend_q) || $past(i_insn_done))
    else $error("destination stored without completion");

  a_dest_then_vec: assert property (
    (dst_ev && vec_ev && !pend_q) |=>
      (o_wr_en && o_wr_info == INFO_DST) ##1
      (o_wr_en && o_wr_info == INFO_VEC))
    else $error("destination and vector out of order");

  a_slot_order: assert property (
    (o_wr_en && seen_q) |-> o_wr_idx == IDX_W'(last_idx_q + 1'b1))
    else $error("trace slot skipped or repeated");

  c_source: cover property (src_ev ##1 o_wr_en);
  c_dest:   cover property (dst_ev ##1 o_wr_en);
  c_vector: cover property (vec_ev && !cof_ev ##1 o_wr_en);
  c_both:   cover property (dst_ev && vec_ev ##1 pend_q ##1 o_wr_en);

endmodule : tfcc_capture
`default_nettype wire

// File: tfcc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// core stand-in: presents completion and vector events
// ==========================================================
module tfcc_core_model
  import tfcc_pkg::*;
(
  output var logic              o_done,      // completion pulse
  output var tfcc_class_t       o_class,     // class of that insn
  output var logic              o_taken,     // branch taken
  output var logic [ADDR_W-1:0] o_insn_addr, // source address
  output var logic [ADDR_W-1:0] o_dest_addr, // destination
  output var logic              o_irq,       // vector fetch pulse
  output var logic              o_background_entry_instruction,      // debug-state vector
  output var logic [ADDR_W-1:0] o_vec_addr   // vector address
);
  initial begin
    o_done      = 1'b0;
    o_class     = TFCC_CLS_OTHER;
    o_taken     = 1'b0;
    o_insn_addr = 18'h00000;
    o_dest_addr = 18'h00000;
    o_irq       = 1'b0;
    o_background_entry_instruction      = 1'b0;
    o_vec_addr  = 18'h00000;
  end
  // called just after a rising edge; holds for one cycle
  task automatic present(input logic d, input tfcc_class_t c, input logic t,
      input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] dst,
      input logic q, input logic b, input logic [ADDR_W-1:0] v);
    o_done      <= d;
    o_class     <= c;
    o_taken     <= t;
    o_insn_addr <= s;
    o_dest_addr <= dst;
    o_irq       <= q;
    o_background_entry_instruction      <= b;
    o_vec_addr  <= v;
  endtask : present
  // no event; address lines toggle so stale values never look valid
  task automatic idle();
    o_done      <= 1'b0;
    o_irq       <= 1'b0;
    o_insn_addr <= ~o_insn_addr;
    o_dest_addr <= ~o_dest_addr;
    o_vec_addr  <= ~o_vec_addr;
  endtask : idle
endmodule : tfcc_core_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench with a queue model of the buffer
// ==========================================================
module tb;
  import tfcc_pkg::*;
  localparam int DEP = 4; // small depth so the index wraps often
  logic clk, rst, en, done, taken, irq, background_entry_instruction, wr_en;
  tfcc_class_t cls;
  logic [ADDR_W-1:0] ia, da, va, wr_addr;
  logic [1:0] wr_idx;
  logic [INFO_W-1:0] wr_info;
  int fails = 0, samples_checked = 0, exp_idx = 0, age = 0;
  int seed = 32'h0c96;
  logic [ADDR_W-1:0] q_addr[$];
  logic [INFO_W-1:0] q_info[$];
  tfcc_core_model u_core (.o_done(done), .o_class(cls), .o_taken(taken),
    .o_insn_addr(ia), .o_dest_addr(da), .o_irq(irq), .o_background_entry_instruction(background_entry_instruction),
    .o_vec_addr(va));
  tfcc_capture #(.DEPTH(DEP)) u_dut (.i_clk(clk), .i_rst(rst),
    .i_trace_en(en), .i_insn_done(done), .i_insn_class(cls),
    .i_taken(taken), .i_insn_addr(ia), .i_dest_addr(da), .i_irq_taken(irq),
    .i_vec_background_entry_instruction(background_entry_instruction), .i_vec_addr(va), .o_wr_en(wr_en), .o_wr_idx(wr_idx),
    .o_wr_addr(wr_addr), .o_wr_info(wr_info));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (e !== s) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic results();
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // one event group; the model queue learns what must be written
  task automatic ev(bit e, bit dn, int c, bit t, bit q, bit b);
    logic [ADDR_W-1:0] s, d, v;
    s = 18'($random(seed));
    d = 18'($random(seed));
    v = 18'($random(seed));
    @(posedge clk);
    en <= e;
    u_core.present(dn, tfcc_class_t'(c), t, s, d, q, b, v);
    if (e && dn && c == 1 && t) begin
      q_addr.push_back(s);
      q_info.push_back(INFO_SRC);
    end
    if (e && dn && (c == 2 || c == 4)) begin
      q_addr.push_back(d);
      q_info.push_back(INFO_DST);
    end
    if (e && q && !b) begin
      q_addr.push_back(v);
      q_info.push_back(INFO_VEC);
    end
    if (dn && q) begin
      @(posedge clk);
      u_core.idle(); // core never stacks two events after a collision
    end
  endtask : ev
  // every write is compared with the head of the model queue
  always @(posedge clk) begin
    if (rst) begin
      chk("wr_en in reset", 0, 32'(wr_en));
      chk("idx in reset", 0, 32'(wr_idx));
    end else if (wr_en === 1'b1) begin
      if (q_addr.size() == 0) chk("unexpected write", 0, 1);
      else begin
        chk("addr", 32'(q_addr.pop_front()), 32'(wr_addr));
        chk("info", 32'(q_info.pop_front()), 32'(wr_info));
        chk("idx", 32'(exp_idx), 32'(wr_idx));
        exp_idx = (exp_idx + 1) % DEP;
        age = 0;
      end
    end else if (q_addr.size() > 0) begin
      age++;
      if (age > 3) chk("write latency", 0, 32'(age));
    end
  end
  initial begin
    #(50 * 20000);
    fails++;
    results();
  end
  initial begin
    rst = 1'b1;
    en  = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // every class, taken flag, vector and debug-vector combination
    // taken flag from bit 3 so branches see both values with vectors
    for (int i = 0; i < 48; i++) begin
      ev(1, 1, i % 6, i[3],
         i[1], i[2]);
    end
    for (int i = 0; i < 400; i++) begin
      ev(($random(seed) & 3) != 0, 1'($random(seed)),
         $unsigned($random(seed)) % 6, 1'($random(seed)),
         ($random(seed) & 3) == 0,
         ($random(seed) & 3) == 0);
      if (i == 200) begin
        @(posedge clk);
        u_core.idle();
        repeat (4) @(posedge clk);
        chk("drained", 0, q_addr.size());
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        exp_idx = 0;
      end
    end
    @(posedge clk);
    u_core.idle();
    repeat (5) @(posedge clk);
    chk("drained", 0, q_addr.size());
    results();
  end
endmodule : tb
`default_nettype wire
